// ==== rtl/tms_beeper.sv ====
// buzzer sequencer producing one or two fixed length beeps
`default_nettype none
module tms_beeper #(
   parameter int unsigned BEEP_CYC = 16
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // request
   input  wire logic start_one,
   input  wire logic start_two,
   // status and buzzer
   output var  logic busy,
   output var  logic buzzer_q
);
   localparam int CW = $clog2(BEEP_CYC + 1);
   logic [CW-1:0] cnt_q;
   logic [1:0]    phase_q; // remaining on/off phases

   assign busy = (phase_q != 2'h0);

   // on, gap, on phases each one beep long
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q    <= '0;
         phase_q  <= 2'h0;
         buzzer_q <= 1'b0;
      end else if (!busy && (start_one || start_two)) begin
         cnt_q    <= '0;
         phase_q  <= start_two ? 2'h3 : 2'h1;
         buzzer_q <= 1'b1;
      end else if (busy) begin
         if (cnt_q >= CW'(BEEP_CYC - 1)) begin
            cnt_q    <= '0;
            phase_q  <= phase_q - 2'h1;
            buzzer_q <= (phase_q == 2'h2);
         end else begin
            cnt_q <= cnt_q + CW'(1);
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/tms_cfg.svh ====
// constants for the trigger merge and setup select block
`ifndef TMS_CFG_SVH
`define TMS_CFG_SVH
`define TMS_CLK_HZ         125000000
`define TMS_READY_MS       1500
`define TMS_READY_CYC      ((`TMS_CLK_HZ / 1000) * `TMS_READY_MS)
`define TMS_DEBOUNCE_US    10000
`define TMS_DEBOUNCE_CYC   ((`TMS_CLK_HZ / 1000000) * `TMS_DEBOUNCE_US)
`define TMS_BEEP_MS        80
`define TMS_BEEP_CYC       ((`TMS_CLK_HZ / 1000) * `TMS_BEEP_MS)
`define TMS_FLASH_MS       250
`define TMS_FLASH_CYC      ((`TMS_CLK_HZ / 1000) * `TMS_FLASH_MS)
`define TMS_SEL_POS_D      4'hD
`define TMS_SEL_POS_2      4'h2
`define TMS_LED_OFF        2'h0
`define TMS_LED_GREEN      2'h1
`define TMS_LED_ORANGE     2'h2
`define TMS_LED_RED        2'h3
`endif

// ==== rtl/tms_pkg.sv ====
// types for the trigger merge and setup select block
`default_nettype none
package tms_pkg;
   typedef enum logic [2:0] {
      TMS_ST_BOOT    = 3'h0,
      TMS_ST_LOAD    = 3'h1,
      TMS_ST_STRAP   = 3'h2,
      TMS_ST_BEEP2   = 3'h3,
      TMS_ST_SETUP   = 3'h4,
      TMS_ST_SAVE    = 3'h5,
      TMS_ST_RUN     = 3'h6
   } tms_state_e;
   typedef logic [1:0] tms_led_t;
endpackage
`default_nettype wire

// ==== rtl/tms_sync_filter.sv ====
// three flop synchroniser with optional debounce for one pin
`default_nettype none
module tms_sync_filter #(
   parameter int unsigned STABLE_CYC = 1,
   parameter logic        INIT       = 1'b1
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // pin and filtered level
   input  wire logic pin_in,
   output var  logic level_q
);
   localparam int CW = (STABLE_CYC > 1) ? $clog2(STABLE_CYC + 1) : 1;
   logic [2:0]    sync_q;
   logic [CW-1:0] cnt_q;

   // three flops, the first only feeds the second
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync_q <= {3{INIT}};
      end else begin
         sync_q <= {sync_q[1:0], pin_in};
      end
   end

   // accept a change once stages two and three agree for long enough
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q   <= '0;
         level_q <= INIT;
      end else if (sync_q[1] != sync_q[2] || sync_q[2] == level_q) begin
         cnt_q <= '0;
      end else if (cnt_q >= CW'(STABLE_CYC - 1)) begin
         cnt_q   <= '0;
         level_q <= sync_q[2];
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end
endmodule
`default_nettype wire

// ==== rtl/tms_top.sv ====
// trigger merge, power-up setup select and panel feedback
//
// Overview of operation
// - indicator orange from power-up, green once normal operation begins.
// - at power-up, selector at D and lever off neutral enters setup.
// - entering setup sounds a double beep before lever strokes count.
// - rear indicator flashes orange throughout the setup state.
// - selector 2 plus lever up selects test pattern, single beep.
// - selector 2 plus lever down returns to regular sensor images.
// - selection saved in non-volatile storage and reapplied every power-up.
// - shutter trigger accepted on auxiliary pin and on link line.
// - both triggers merged as active-low OR.
// - shutter starts only on trailing edge of combined low pulse.
// - polarity inversion applies to link trigger only, aux stays low.
`include "tms_cfg.svh"
`default_nettype none
module tms_top #(
   parameter int unsigned READY_CYC    = `TMS_READY_CYC,
   parameter int unsigned DEBOUNCE_CYC = `TMS_DEBOUNCE_CYC,
   parameter int unsigned BEEP_CYC     = `TMS_BEEP_CYC,
   parameter int unsigned FLASH_CYC    = `TMS_FLASH_CYC
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // panel switches
   input  wire logic [3:0] mode_sel_in,
   input  wire logic       lever_up_n,
   input  wire logic       lever_down_n,
   // shutter triggers
   input  wire logic       aux_trigger_in,
   input  wire logic       link_trigger_in,
   input  wire logic       link_invert,
   // non-volatile selection store
   input  wire logic       nv_ready,
   input  wire logic       nv_rd_data,
   output var  logic       nv_rd_req,
   output var  logic       nv_wr_req,
   output var  logic       nv_wr_data,
   // results
   output var  logic       test_pattern_en_q,
   output var  logic       shutter_start_q,
   output var  logic       trigger_low_q,
   output var  logic       setup_active,
   // panel feedback
   output var  tms_pkg::tms_led_t led_q,
   output var  logic       buzzer
);
   tms_pkg::tms_state_e state_q;
   tms_pkg::tms_state_e state_d;
   logic [3:0]  sel_q;
   logic        up_lvl;
   logic        dn_lvl;
   logic        up_prev_q;
   logic        dn_prev_q;
   logic        up_stroke;
   logic        dn_stroke;
   logic        aux_lvl;
   logic        link_lvl;
   logic        link_pin_n;
   logic        link_low;
   logic        merged_n;
   logic        merged_prev_q;
   logic        beep_busy;
   logic        beep_one;
   logic        beep_two;
   logic        want_q;
   logic        lever_neutral_seen_q;
   logic [31:0] ready_cnt_q;
   logic [31:0] flash_cnt_q;
   logic        flash_q;

   // contact closed: level went from high to low
   function automatic logic tms_fell(input logic prev, input logic cur);
      return prev && !cur;
   endfunction

   // low pulse ended: level went from low to high
   function automatic logic tms_rose(input logic prev, input logic cur);
      return !prev && cur;
   endfunction

   // last count of a period of lim cycles
   function automatic logic tms_expired(input logic [31:0] cnt,
                                        input int unsigned lim);
      return cnt >= lim - 1;
   endfunction

   // selector bits synchronised and debounced
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sel
         tms_sync_filter #(.STABLE_CYC(DEBOUNCE_CYC), .INIT(1'b0)) u_sel (
            .clock   (clock),
            .reset_n (reset_n),
            .pin_in  (mode_sel_in[gi]),
            .level_q (sel_q[gi])
         );
      end
   endgenerate

   // lever contacts, active low, debounced
   tms_sync_filter #(.STABLE_CYC(DEBOUNCE_CYC), .INIT(1'b1)) u_up (
      .clock   (clock),
      .reset_n (reset_n),
      .pin_in  (lever_up_n),
      .level_q (up_lvl)
   );
   tms_sync_filter #(.STABLE_CYC(DEBOUNCE_CYC), .INIT(1'b1)) u_dn (
      .clock   (clock),
      .reset_n (reset_n),
      .pin_in  (lever_down_n),
      .level_q (dn_lvl)
   );

   // link polarity folded in ahead of its synchroniser, so the fixed
   // reset level of the flops can never fake a trailing edge
   assign link_pin_n = link_invert ? !link_trigger_in
                                   : link_trigger_in;

   // trigger pins, synchronised only so short pulses survive
   tms_sync_filter #(.STABLE_CYC(1), .INIT(1'b1)) u_aux (
      .clock   (clock),
      .reset_n (reset_n),
      .pin_in  (aux_trigger_in),
      .level_q (aux_lvl)
   );
   tms_sync_filter #(.STABLE_CYC(1), .INIT(1'b1)) u_link (
      .clock   (clock),
      .reset_n (reset_n),
      .pin_in  (link_pin_n),
      .level_q (link_lvl)
   );

   // link side already active low after the synchroniser
   assign link_low = !link_lvl;
   // combined trigger low whenever either side is active
   assign merged_n = !(!aux_lvl || link_low);

   // combined trigger history for edge detection
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         merged_prev_q <= 1'b1;
      end else begin
         merged_prev_q <= merged_n;
      end
   end

   // trailing edge of a low pulse starts the shutter
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         shutter_start_q <= 1'b0;
      end else begin
         shutter_start_q <= tms_rose(merged_prev_q, merged_n);
      end
   end

   // registered view of the combined trigger level
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         trigger_low_q <= 1'b0;
      end else begin
         trigger_low_q <= !merged_n;
      end
   end

   // up contact history for stroke detection
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         up_prev_q <= 1'b1;
      end else begin
         up_prev_q <= up_lvl;
      end
   end

   // down contact history for stroke detection
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dn_prev_q <= 1'b1;
      end else begin
         dn_prev_q <= dn_lvl;
      end
   end
   // a stroke is the contact closing
   assign up_stroke = tms_fell(up_prev_q, up_lvl);
   assign dn_stroke = tms_fell(dn_prev_q, dn_lvl);

   // power-up delay, lets the switch filters settle too
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ready_cnt_q <= 32'h0000_0000;
      end else if (state_q == tms_pkg::TMS_ST_BOOT) begin
         ready_cnt_q <= ready_cnt_q + 32'h0000_0001;
      end
   end

   // stroke only counts after lever has been back in neutral
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lever_neutral_seen_q <= 1'b0;
      end else if (state_q != tms_pkg::TMS_ST_SETUP) begin
         lever_neutral_seen_q <= 1'b0;
      end else if (up_lvl && dn_lvl) begin
         lever_neutral_seen_q <= 1'b1;
      end
   end

   // main sequence
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         tms_pkg::TMS_ST_BOOT: begin
            if (tms_expired(ready_cnt_q, READY_CYC) && nv_ready) begin
               state_d = tms_pkg::TMS_ST_LOAD;
            end
         end
         tms_pkg::TMS_ST_LOAD: begin
            state_d = tms_pkg::TMS_ST_STRAP;
         end
         tms_pkg::TMS_ST_STRAP: begin
            if (sel_q == `TMS_SEL_POS_D && (!up_lvl || !dn_lvl)) begin
               state_d = tms_pkg::TMS_ST_BEEP2;
            end else begin
               state_d = tms_pkg::TMS_ST_RUN;
            end
         end
         tms_pkg::TMS_ST_BEEP2: begin
            if (!beep_busy) begin
               state_d = tms_pkg::TMS_ST_SETUP;
            end
         end
         tms_pkg::TMS_ST_SETUP: begin
            if (lever_neutral_seen_q && sel_q == `TMS_SEL_POS_2
                && (up_stroke || dn_stroke) && nv_ready) begin
               state_d = tms_pkg::TMS_ST_SAVE;
            end
         end
         tms_pkg::TMS_ST_SAVE: begin
            state_d = tms_pkg::TMS_ST_RUN;
         end
         tms_pkg::TMS_ST_RUN: begin
            state_d = tms_pkg::TMS_ST_RUN;
         end
         default: begin
            state_d = tms_pkg::TMS_ST_BOOT;
         end
      endcase
   end

   // state register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= tms_pkg::TMS_ST_BOOT;
      end else begin
         state_q <= state_d;
      end
   end

   // pending selection: loaded from storage, changed only in setup
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         want_q <= 1'b0;
      end else if (state_q == tms_pkg::TMS_ST_LOAD) begin
         want_q <= nv_rd_data;
      end else if (state_q == tms_pkg::TMS_ST_SETUP
                   && state_d == tms_pkg::TMS_ST_SAVE) begin
         want_q <= up_stroke;
      end
   end

   // applied selection: from storage at power-up, else after a save
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         test_pattern_en_q <= 1'b0;
      end else if (state_q == tms_pkg::TMS_ST_LOAD) begin
         test_pattern_en_q <= nv_rd_data;
      end else if (state_q == tms_pkg::TMS_ST_SAVE) begin
         test_pattern_en_q <= want_q;
      end
   end

   // storage strobes
   assign nv_rd_req  = (state_q == tms_pkg::TMS_ST_BOOT)
                       && (state_d == tms_pkg::TMS_ST_LOAD);
   assign nv_wr_req  = (state_q == tms_pkg::TMS_ST_SAVE);
   assign nv_wr_data = want_q;

   // setup indication covers the double beep as well
   assign setup_active = (state_q == tms_pkg::TMS_ST_BEEP2)
                         || (state_q == tms_pkg::TMS_ST_SETUP);

   // buzzer requests
   assign beep_two = (state_q == tms_pkg::TMS_ST_STRAP)
                     && (state_d == tms_pkg::TMS_ST_BEEP2);
   assign beep_one = (state_q == tms_pkg::TMS_ST_SAVE)
                     && want_q;

   tms_beeper #(.BEEP_CYC(BEEP_CYC)) u_beep (
      .clock     (clock),
      .reset_n   (reset_n),
      .start_one (beep_one),
      .start_two (beep_two),
      .busy      (beep_busy),
      .buzzer_q  (buzzer)
   );

   // flash timebase for the setup indicator
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flash_cnt_q <= 32'h0000_0000;
      end else if (!setup_active) begin
         flash_cnt_q <= 32'h0000_0000;
      end else if (tms_expired(flash_cnt_q, FLASH_CYC)) begin
         flash_cnt_q <= 32'h0000_0000;
      end else begin
         flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
      end
   end

   // flash phase, starts lit on entry to setup
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flash_q <= 1'b1;
      end else if (!setup_active) begin
         flash_q <= 1'b1;
      end else if (tms_expired(flash_cnt_q, FLASH_CYC)) begin
         flash_q <= !flash_q;
      end
   end

   // indicator colour
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         led_q <= `TMS_LED_ORANGE;
      end else if (setup_active) begin
         led_q <= flash_q ? `TMS_LED_ORANGE : `TMS_LED_OFF;
      end else if (state_q == tms_pkg::TMS_ST_RUN) begin
         led_q <= `TMS_LED_GREEN;
      end else begin
         led_q <= `TMS_LED_ORANGE;
      end
   end
endmodule
`default_nettype wire

// ==== tb/tb_tms_top.sv ====
// self-checking bench for the trigger merge and setup select block
`include "tms_cfg.svh"
`default_nettype none
module tb_tms_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock, reset_n, lever_up_n, lever_down_n, buzzer;
   logic [3:0] mode_sel_in;
   logic       aux_trigger_in, link_trigger_in, link_invert;
   logic       nv_ready, nv_rd_data, nv_rd_req, nv_wr_req, nv_wr_data;
   logic       test_pattern_en_q, shutter_start_q, trigger_low_q;
   logic       setup_active, bz_d;
   tms_pkg::tms_led_t led_q;
   int         fails = 0, cmp_count = 0, bz_n = 0, sh_n = 0, wr_n = 0;

   tms_top #(.READY_CYC(8), .DEBOUNCE_CYC(2), .BEEP_CYC(4), .FLASH_CYC(4))
   u_tms_top (.clock, .reset_n, .mode_sel_in, .lever_up_n, .lever_down_n,
      .aux_trigger_in, .link_trigger_in, .link_invert, .nv_ready,
      .nv_rd_data, .nv_rd_req, .nv_wr_req, .nv_wr_data, .test_pattern_en_q,
      .shutter_start_q, .trigger_low_q, .setup_active, .led_q, .buzzer);
   tms_nv_model #(.READY_DLY(20)) u_tms_nv_model (.clock, .reset_n,
      .nv_rd_req, .nv_wr_req, .nv_wr_data, .nv_ready, .nv_rd_data);

   // clock at 8 ns
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // counts of beeps, shutter pulses and store writes
   always @(posedge clock) begin
      bz_d <= buzzer;
      if (buzzer === 1'b1 && bz_d === 1'b0)
         bz_n <= bz_n + 1;
      if (shutter_start_q === 1'b1)
         sh_n <= sh_n + 1;
      if (nv_wr_req === 1'b1)
         wr_n <= wr_n + 1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // power cycle with the panel strapped as given
   task automatic power_up(input logic [3:0] sel, input logic up_n,
                           input logic dn_n);
      @(posedge clock);
      reset_n <= 1'b0;
      mode_sel_in <= sel;
      lever_up_n <= up_n;
      lever_down_n <= dn_n;
      cyc(12);
      reset_n <= 1'b1;
      cyc(2);
      chk(led_q, `TMS_LED_ORANGE);
   endtask
   task automatic wait_green();
      for (int i = 0; i < 300 && led_q !== `TMS_LED_GREEN; i++)
         @(posedge clock);
      chk(led_q, `TMS_LED_GREEN);
   endtask
   // plain power-up, selection reloaded from the store
   task automatic boot_run(input logic [3:0] sel, input logic up_n,
                           input logic dn_n, input logic tp);
      power_up(sel, up_n, dn_n);
      wait_green();
      chk(setup_active, 1'b0);
      chk(test_pattern_en_q, tp);
      lever_up_n <= 1'b1;
      lever_down_n <= 1'b1;
   endtask
   // setup entry by strap, one stroke with selector at 2
   task automatic setup_sel(input logic up);
      int b0, w0, orn;
      w0 = wr_n;
      orn = 0;
      power_up(`TMS_SEL_POS_D, !up, up);
      b0 = bz_n;
      for (int i = 0; i < 300 && setup_active !== 1'b1; i++)
         @(posedge clock);
      chk(setup_active, 1'b1);
      cyc(40);
      chk(8'(bz_n - b0), 8'h02);
      chk(8'(wr_n - w0), 8'h00);
      for (int i = 0; i < 16; i++) begin
         cyc(1);
         orn += (led_q === `TMS_LED_ORANGE);
      end
      chk(orn > 0 && orn < 16, 1'b1);
      lever_up_n <= 1'b1;
      lever_down_n <= 1'b1;
      cyc(10);
      mode_sel_in <= `TMS_SEL_POS_2;
      cyc(10);
      b0 = bz_n;
      if (up)
         lever_up_n <= 1'b0;
      else
         lever_down_n <= 1'b0;
      for (int i = 0; i < 50 && nv_wr_req !== 1'b1; i++)
         @(posedge clock);
      chk(nv_wr_data, up);
      cyc(2);
      chk(test_pattern_en_q, up);
      cyc(30);
      chk(8'(bz_n - b0), {7'h00, up});
      lever_up_n <= 1'b1;
      lever_down_n <= 1'b1;
      wait_green();
   endtask
   // strokes in normal running leave the selection alone
   task automatic run_strokes();
      int w0;
      w0 = wr_n;
      mode_sel_in <= `TMS_SEL_POS_2;
      lever_down_n <= 1'b0;
      cyc(10);
      lever_down_n <= 1'b1;
      cyc(10);
      chk(8'(wr_n - w0), 8'h00);
      chk(test_pattern_en_q, 1'b1);
   endtask
   // merged trigger on both pins and link polarity
   task automatic trig();
      int s0;
      s0 = sh_n;
      aux_trigger_in <= 1'b0;
      cyc(8);
      chk(trigger_low_q, 1'b1);
      aux_trigger_in <= 1'b1;
      cyc(8);
      chk(8'(sh_n - s0), 8'h01);
      link_trigger_in <= 1'b0;
      cyc(8);
      aux_trigger_in <= 1'b0;
      cyc(8);
      aux_trigger_in <= 1'b1;
      cyc(8);
      chk(8'(sh_n - s0), 8'h01);
      chk(trigger_low_q, 1'b1);
      aux_trigger_in <= 1'b0;
      cyc(8);
      link_invert <= 1'b1;
      cyc(8);
      aux_trigger_in <= 1'b1;
      cyc(8);
      link_trigger_in <= 1'b1;
      cyc(8);
      chk(trigger_low_q, 1'b1);
      link_trigger_in <= 1'b0;
      cyc(8);
      chk(8'(sh_n - s0), 8'h03);
   endtask
   // main sequence
   initial begin
      reset_n = 1'b0;
      mode_sel_in = 4'h0;
      lever_up_n = 1'b1;
      lever_down_n = 1'b1;
      aux_trigger_in = 1'b1;
      link_trigger_in = 1'b1;
      link_invert = 1'b0;
      boot_run(4'h0, 1'b1, 1'b1, 1'b0);
      setup_sel(1'b1);
      boot_run(4'h0, 1'b1, 1'b1, 1'b1);
      run_strokes();
      trig();
      boot_run(`TMS_SEL_POS_2, 1'b0, 1'b1, 1'b1);
      boot_run(`TMS_SEL_POS_D, 1'b1, 1'b1, 1'b1);
      setup_sel(1'b0);
      boot_run(4'h0, 1'b1, 1'b1, 1'b0);
      give_verdict();
   end
   // watchdog well beyond the expected run
   initial begin
      #200us;
      fails++;
      give_verdict();
   end
endmodule
`default_nettype wire

// ==== tb/tms_nv_model.sv ====
// behavioural non-volatile selection store at the far side
`default_nettype none
module tms_nv_model #(
   parameter int unsigned READY_DLY = 20
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // store port
   input  wire logic nv_rd_req,
   input  wire logic nv_wr_req,
   input  wire logic nv_wr_data,
   output var  logic nv_ready,
   output var  logic nv_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned dly_q;
   logic        store_q = 1'b0;
   // store keeps its bit across resets
   always @(posedge clock)
      if (nv_wr_req)
         store_q <= nv_wr_data;
   // slow readiness after each reset
   always @(posedge clock or negedge reset_n)
      if (!reset_n)
         dly_q <= 0;
      else if (dly_q < READY_DLY)
         dly_q <= dly_q + 1;
   assign nv_ready   = (dly_q == READY_DLY);
   // garbage until ready, then the stored bit
   assign nv_rd_data = nv_ready ? store_q : !store_q;
endmodule
`default_nettype wire

// ==== tb/tms_top_chk.sv ====
// assertions on the ports of the trigger merge and setup select top
`include "tms_cfg.svh"
`default_nettype none
module tms_top_chk (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // watched ports
   input  wire logic              aux_trigger_in,
   input  wire logic              link_trigger_in,
   input  wire logic              link_invert,
   input  wire logic              nv_rd_req,
   input  wire logic              nv_wr_req,
   input  wire logic              nv_wr_data,
   input  wire logic              test_pattern_en_q,
   input  wire logic              shutter_start_q,
   input  wire logic              setup_active,
   input  wire tms_pkg::tms_led_t led_q,
   input  wire logic              buzzer
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic act;
   // merged trigger active at the pins
   assign act = !aux_trigger_in || (link_trigger_in == link_invert);
   AST_SHUT_EDGE: assert property (
      shutter_start_q == ($past(act, 6) && !$past(act, 5)))
      else $error("shutter pulse not at trailing edge");
   AST_SHUT_ONE: assert property (
      shutter_start_q |=> !shutter_start_q)
      else $error("shutter pulse too long");
   AST_SETUP_LED: assert property (
      setup_active |-> led_q != `TMS_LED_GREEN)
      else $error("green indicator in setup");
   AST_SETUP_BEEP: assert property (
      $rose(setup_active) |-> ##[0:12] buzzer)
      else $error("no beep on setup entry");
   AST_WR_ONE: assert property (
      nv_wr_req |=> !nv_wr_req)
      else $error("store write too long");
   AST_WR_SETUP: assert property (
      nv_wr_req |-> $past(setup_active))
      else $error("store write outside setup");
   AST_TP_UPD: assert property (
      nv_wr_req |=> test_pattern_en_q == $past(nv_wr_data))
      else $error("selection not applied");
   AST_TP_HOLD: assert property (
      setup_active |=> $stable(test_pattern_en_q))
      else $error("selection moved in setup");
   AST_RD_ONE: assert property (
      nv_rd_req |=> !nv_rd_req)
      else $error("store read too long");
   AST_RD_WR: assert property (
      !(nv_rd_req && nv_wr_req))
      else $error("store read and write together");
   COV_SHUT: cover property (shutter_start_q);
   COV_TP_ON: cover property (nv_wr_req && nv_wr_data);
   COV_TP_OFF: cover property (nv_wr_req && !nv_wr_data);
   COV_SETUP: cover property ($rose(setup_active));
endmodule
bind tms_top tms_top_chk u_tms_top_chk (.clock, .reset_n, .aux_trigger_in,
   .link_trigger_in, .link_invert, .nv_rd_req, .nv_wr_req, .nv_wr_data,
   .test_pattern_en_q, .shutter_start_q, .setup_active, .led_q, .buzzer);
`default_nettype wire
